// file: psc_pkg.sv
// Package with constants and types of the program selector change logic.
package psc_pkg;
    localparam int NUM_PROG = 5;
    localparam int PROG_W = 3;
    localparam int NAME_CHARS = 22;
    localparam int CLK_MHZ = 250;
    // Pulse lengths in microseconds.
    localparam int DIRECT_DROP_US = 10000;
    localparam int LOGIC1_DROP_US = 20000;
    localparam int DIRECT_DROP_CYC = DIRECT_DROP_US * CLK_MHZ;
    localparam int LOGIC1_DROP_CYC = LOGIC1_DROP_US * CLK_MHZ;
    localparam int CNT_W = 32;
    localparam logic [PROG_W-1:0] RESET_PROG = 3'h0;
    localparam logic [4:0] RESET_SEL = 5'h01;

    typedef enum logic [1:0] {
        PSC_RUN,
        PSC_WAIT_DELAY,
        PSC_CHANGE
    } psc_state_t;

    function automatic logic psc_onehot(input logic [NUM_PROG-1:0] v,
                                        input logic [PROG_W-1:0] n);
        int c;
        c = 0;
        for (int i = 0; i < NUM_PROG; i++) begin
            if (v[i] && i < int'(n)) begin
                c = c + 1;
            end else if (v[i]) begin
                c = c + 2;
            end
        end
        return c == 1;
    endfunction : psc_onehot
endpackage : psc_pkg

// file: psc_filter.sv
// Stability filter for the selector inputs.
module psc_filter #(
    parameter int WIDTH = 5,
    parameter int CNT_W = 32
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw and filtered selection.
    input wire logic [WIDTH-1:0] raw,
    input wire logic [CNT_W-1:0] filter_cycles,
    output logic [WIDTH-1:0] stable,
    output logic stable_pulse
);
    typedef struct packed {
        logic [WIDTH-1:0] last;
        logic [WIDTH-1:0] stable;
        logic [CNT_W-1:0] cnt;
        logic pulse;
    } psc_filt_t;
    psc_filt_t s, next_s;

    // A new value is taken once it has stood for the filter time.
    always_comb begin
        next_s = s;
        next_s.pulse = 1'b0;
        if (raw != s.last) begin
            next_s.last = raw;
            next_s.cnt = '0;
        end else if (raw != s.stable) begin
            if (s.cnt + 1'b1 >= filter_cycles) begin
                next_s.stable = raw;
                next_s.pulse = 1'b1;
                next_s.cnt = '0;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign stable = s.stable;
    assign stable_pulse = s.pulse;

    property p_filter_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (raw != s.last) |=> $stable(stable);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("stable value changed on an unsettled input");
endmodule : psc_filter

// file: psc_timer.sv
// Down counter that holds a level while it runs.
module psc_timer #(
    parameter int CNT_W = 32
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control.
    input wire logic start,
    input wire logic [CNT_W-1:0] cycles,
    output logic busy
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } psc_tmr_t;
    psc_tmr_t s, next_s;

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.cnt = cycles;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = (s.cnt != '0);

    property p_timer_load;
        @(posedge ref_clk) disable iff (!rst_n)
        (start && cycles > 1) |=> busy;
    endproperty
    a_timer_load: assert property (p_timer_load)
        else $error("timer not running after start");
endmodule : psc_timer

// file: psc_program_selector.sv
// Program selection and program change control.
module psc_program_selector #(
    parameter int NUM_PROG = psc_pkg::NUM_PROG,
    parameter int CNT_W = psc_pkg::CNT_W,
    parameter int DIRECT_DROP_CYC = psc_pkg::DIRECT_DROP_CYC,
    parameter int LOGIC1_DROP_CYC = psc_pkg::LOGIC1_DROP_CYC
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Configuration.
    input wire logic [psc_pkg::PROG_W-1:0] prog_count,
    input wire logic [8*psc_pkg::NAME_CHARS-1:0] app_name_in,
    input wire logic app_name_load,
    input wire logic sel_tested,
    input wire logic [NUM_PROG-1:0] sel_test_pulse,
    input wire logic mode_switch_a,
    input wire logic mode_switch_b,
    input wire logic forward_enable,
    input wire logic forward_simultaneous,
    input wire logic [CNT_W-1:0] filter_cycles,
    input wire logic [CNT_W-1:0] changeover_cycles,
    // Per application routing of the current program.
    input wire logic [NUM_PROG-1:0] direct_route_a,
    input wire logic [NUM_PROG-1:0] direct_route_b,
    input wire logic [NUM_PROG-1:0] logic1_route_a,
    input wire logic [NUM_PROG-1:0] logic1_route_b,
    // Selector and local inputs.
    input wire logic [NUM_PROG-1:0] sel_in,
    input wire logic [NUM_PROG-1:0] local_in,
    // Application status.
    input wire logic bypass_active,
    input wire logic teach_active,
    input wire logic delay_running,
    input wire logic [1:0] app_out_req,
    // Outputs.
    output logic [1:0] app_out,
    output logic bypass_cancel,
    output logic [psc_pkg::PROG_W-1:0] active_prog,
    output logic changing,
    output logic app_restart,
    output logic [NUM_PROG-1:0] peer_data,
    output logic peer_valid,
    output logic sel_invalid,
    output logic [8*psc_pkg::NAME_CHARS-1:0] app_name
);
    typedef struct packed {
        logic [1:0] rst_sync;
        psc_pkg::psc_state_t st;
        logic [psc_pkg::PROG_W-1:0] prog;
        logic [psc_pkg::PROG_W-1:0] pend;
        logic [1:0] hold_val;
        logic [1:0] app_out;
        logic bypass_cancel;
        logic changing;
        logic app_restart;
        logic [NUM_PROG-1:0] peer_data;
        logic peer_valid;
        logic sel_invalid;
        logic [8*psc_pkg::NAME_CHARS-1:0] app_name;
    } psc_top_t;
    psc_top_t s, next_s;

    logic rst_n;
    logic [NUM_PROG-1:0] sel_eval;
    logic [NUM_PROG-1:0] sel_stable;
    logic sel_new;
    logic [NUM_PROG-1:0] direct_a_cur;
    logic [NUM_PROG-1:0] direct_b_cur;
    logic start_co, start_direct, start_logic1;
    logic co_busy, direct_busy, logic1_busy;
    logic [CNT_W-1:0] direct_cyc, logic1_cyc;
    logic [psc_pkg::PROG_W-1:0] sel_idx;
    logic [1:0] mode_sw;
    logic [1:0] drop_direct;
    logic [1:0] drop_logic1;

    assign rst_n = s.rst_sync[1];
    assign mode_sw = {mode_switch_b, mode_switch_a};
    assign direct_cyc = CNT_W'(DIRECT_DROP_CYC);
    assign logic1_cyc = CNT_W'(LOGIC1_DROP_CYC);
    assign direct_a_cur = direct_route_a;
    assign direct_b_cur = direct_route_b;

    // With testing, a selector input counts only while its pulse echo is low.
    assign sel_eval = sel_tested ? (sel_in & ~sel_test_pulse) : sel_in;

    psc_filter #(
        .WIDTH(NUM_PROG),
        .CNT_W(CNT_W)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw(sel_eval),
        .filter_cycles(filter_cycles),
        .stable(sel_stable),
        .stable_pulse(sel_new)
    );

    psc_timer #(.CNT_W(CNT_W)) u_changeover (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(start_co),
        .cycles(changeover_cycles),
        .busy(co_busy)
    );

    psc_timer #(.CNT_W(CNT_W)) u_direct (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(start_direct),
        .cycles(direct_cyc),
        .busy(direct_busy)
    );

    psc_timer #(.CNT_W(CNT_W)) u_logic1 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(start_logic1),
        .cycles(logic1_cyc),
        .busy(logic1_busy)
    );

    // Index of the single active selector input.
    always_comb begin
        sel_idx = psc_pkg::RESET_PROG;
        for (int i = 0; i < NUM_PROG; i++) begin
            if (sel_stable[i]) begin
                sel_idx = psc_pkg::PROG_W'(i);
            end
        end
    end

    // Which applications see a short drop for the new program.
    always_comb begin
        drop_direct = 2'b00;
        drop_logic1 = 2'b00;
        drop_direct[0] = direct_a_cur[s.pend] && !mode_sw[0];
        drop_direct[1] = direct_b_cur[s.pend] && !mode_sw[1];
        drop_logic1[0] = logic1_route_a[s.pend] && !mode_sw[0];
        drop_logic1[1] = logic1_route_b[s.pend] && !mode_sw[1];
    end

    assign start_co = (s.st == psc_pkg::PSC_CHANGE) && !s.changing
                      && (mode_sw != 2'b00);
    assign start_direct = (s.st == psc_pkg::PSC_CHANGE) && !s.changing
                          && (drop_direct != 2'b00);
    assign start_logic1 = (s.st == psc_pkg::PSC_CHANGE) && !s.changing
                          && (drop_logic1 != 2'b00);

    always_comb begin
        next_s = s;
        next_s.rst_sync = {s.rst_sync[0], 1'b1};
        next_s.bypass_cancel = 1'b0;
        next_s.app_restart = 1'b0;
        next_s.peer_valid = 1'b0;
        // Selection is invalid unless one configured input stands alone.
        next_s.sel_invalid = !psc_pkg::psc_onehot(sel_stable,
                                                  prog_count);
        if (app_name_load) begin
            next_s.app_name = app_name_in;
        end
        case (s.st)
            psc_pkg::PSC_RUN: begin
                next_s.changing = 1'b0;
                next_s.app_out = app_out_req;
                next_s.hold_val = app_out_req;
                if (sel_new && !next_s.sel_invalid && sel_idx != s.prog
                        && sel_idx < prog_count) begin
                    next_s.pend = sel_idx;
                    next_s.st = psc_pkg::PSC_WAIT_DELAY;
                end
            end
            psc_pkg::PSC_WAIT_DELAY: begin
                next_s.app_out = app_out_req;
                next_s.hold_val = app_out_req;
                if (bypass_active) begin
                    next_s.bypass_cancel = 1'b1;
                end
                // Stay in the old program while teach-in or delay runs.
                if (!teach_active && !delay_running
                        && !bypass_active) begin
                    next_s.st = psc_pkg::PSC_CHANGE;
                end
            end
            psc_pkg::PSC_CHANGE: begin
                for (int a = 0; a < 2; a++) begin
                    if (mode_sw[a]) begin
                        next_s.app_out[a] = 1'b0;
                    end else if (s.changing
                            && ((direct_busy && drop_direct[a])
                            || (logic1_busy && drop_logic1[a]))) begin
                        next_s.app_out[a] = 1'b0;
                    end else begin
                        next_s.app_out[a] = s.hold_val[a];
                    end
                end
                if (!s.changing) begin
                    next_s.changing = 1'b1;
                    next_s.prog = s.pend;
                    next_s.peer_valid = forward_enable;
                end else if (!co_busy && !direct_busy
                        && !logic1_busy) begin
                    next_s.changing = 1'b0;
                    next_s.app_restart = (mode_sw != 2'b00);
                    next_s.st = psc_pkg::PSC_RUN;
                end
            end
            default: begin
                next_s.st = psc_pkg::PSC_RUN;
            end
        endcase
        // Peer gets selector state or local inputs; its setup is unchecked.
        if (forward_simultaneous) begin
            next_s.peer_data = NUM_PROG'(1) << next_s.prog;
        end else begin
            next_s.peer_data = local_in;
            next_s.peer_valid = forward_enable;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else if (!s.rst_sync[1]) begin
            s <= '0;
            s.rst_sync <= next_s.rst_sync;
        end else begin
            s <= next_s;
        end
    end

    assign app_out = s.app_out;
    assign bypass_cancel = s.bypass_cancel;
    assign active_prog = s.prog;
    assign changing = s.changing;
    assign app_restart = s.app_restart;
    assign peer_data = s.peer_data;
    assign peer_valid = s.peer_valid;
    assign sel_invalid = s.sel_invalid;
    assign app_name = s.app_name;

    property p_teach_blocks;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_WAIT_DELAY && teach_active)
            |=> (s.st == psc_pkg::PSC_WAIT_DELAY);
    endproperty
    a_teach_blocks: assert property (p_teach_blocks)
        else $error("program changed during teach-in");

    property p_bypass_cancel;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_WAIT_DELAY && bypass_active)
            |=> bypass_cancel;
    endproperty
    a_bypass_cancel: assert property (p_bypass_cancel)
        else $error("bypass not cancelled before change");

    property p_mode_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_CHANGE && mode_switch_a)
            |=> !app_out[0];
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("output A on during operating mode change");

    property p_prog_stable;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st != psc_pkg::PSC_CHANGE) |=> $stable(active_prog);
    endproperty
    a_prog_stable: assert property (p_prog_stable)
        else $error("program changed outside change state");

    property p_prog_range;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |-> (active_prog < psc_pkg::PROG_W'(NUM_PROG));
    endproperty
    a_prog_range: assert property (p_prog_range)
        else $error("program index out of range");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_CHANGE && s.changing && !mode_switch_a
            && !direct_busy && !logic1_busy)
            |=> (app_out[0] == $past(s.hold_val[0]));
    endproperty
    a_hold: assert property (p_hold)
        else $error("output A not held during program switching");

    property p_forward;
        @(posedge ref_clk) disable iff (!rst_n)
        (forward_simultaneous && s.changing && peer_valid)
            |-> (peer_data == (NUM_PROG'(1) << active_prog));
    endproperty
    a_forward: assert property (p_forward)
        else $error("peer data does not match program");

    property p_run_follow;
        @(posedge ref_clk) disable iff (!rst_n)
        (rst_n && s.st == psc_pkg::PSC_RUN)
            |=> (app_out == $past(app_out_req));
    endproperty
    a_run_follow: assert property (p_run_follow)
        else $error("outputs do not follow application");

    property p_direct_drop;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_CHANGE && s.changing && direct_busy
            && drop_direct[0]) |=> !app_out[0];
    endproperty
    a_direct_drop: assert property (p_direct_drop)
        else $error("output A not dropped for a direct route");

    property p_logic1_drop;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_CHANGE && s.changing && logic1_busy
            && drop_logic1[1]) |=> !app_out[1];
    endproperty
    a_logic1_drop: assert property (p_logic1_drop)
        else $error("output B not dropped for an input 1 route");

    property p_invalid_keep;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == psc_pkg::PSC_RUN
            && !psc_pkg::psc_onehot(sel_stable, prog_count))
            |=> (s.st == psc_pkg::PSC_RUN);
    endproperty
    a_invalid_keep: assert property (p_invalid_keep)
        else $error("invalid selection started a change");
endmodule : psc_program_selector

// file: psc_partner.sv
// Operator selector switch, bypass key and peer device around the selector.
module psc_partner #(
    parameter int NUM_PROG = 5
) (
    // Clock.
    input wire logic ref_clk,
    // Operator commands from the bench.
    input wire logic [2:0] pick,
    input wire logic two_hot,
    input wire logic bypass_on,
    // Signals from the selector block.
    input wire logic bypass_cancel,
    input wire logic [NUM_PROG-1:0] peer_data,
    input wire logic peer_valid,
    // Signals towards the selector block and the bench.
    output logic [NUM_PROG-1:0] sel_in,
    output logic bypass_active,
    output logic [NUM_PROG-1:0] peer_sel
);
    timeunit 1ns;
    timeprecision 1ps;

    // The key switch closes one contact; two_hot models a broken switch.
    always @(posedge ref_clk) begin
        sel_in <= (NUM_PROG'(1) << pick) |
                  (two_hot ? (NUM_PROG'(1) << ((pick + 1) % NUM_PROG)) : '0);
    end

    // The bypass drops only when the block asks for it.
    always @(posedge ref_clk) begin
        if (bypass_cancel) begin
            bypass_active <= 1'b0;
        end else if (bypass_on) begin
            bypass_active <= 1'b1;
        end
    end

    // The peer holds as many programs as the controller.
    always @(posedge ref_clk) begin
        if (peer_valid) begin
            peer_sel <= peer_data;
        end
    end

    initial begin
        bypass_active = 1'b0;
    end
endmodule : psc_partner

// file: psc_program_selector_tb_top.sv
// Self-checking bench of the program selector change logic.
module psc_program_selector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DCYC = 8;
    localparam int LCYC = 16;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] prog_count = 3'h5, pick = 3'h0;
    logic [175:0] app_name_in = '0;
    logic app_name_load = 0, sel_tested = 0, mode_switch_a = 0;
    logic mode_switch_b = 0, forward_enable = 1, forward_simultaneous = 1;
    logic two_hot = 0, bypass_on = 0, teach_active = 0, delay_running = 0;
    logic [4:0] sel_test_pulse = '0, direct_route_a = '0, direct_route_b = '0;
    logic [4:0] logic1_route_a = '0, logic1_route_b = '0, local_in = '0;
    logic [31:0] filter_cycles = 32'h0000_000a;
    logic [31:0] changeover_cycles = 32'h0000_0014;
    logic [1:0] app_out_req = 2'h3;
    logic [1:0] app_out;
    logic [2:0] active_prog;
    logic [4:0] sel_in, peer_data, peer_sel;
    logic [175:0] app_name;
    logic bypass_cancel, changing, app_restart, peer_valid, sel_invalid;
    logic bypass_active;
    int errors = 0, n_compared = 0, cycles = 0, la, lb, rs;

    always #2 ref_clk = ~ref_clk;

    psc_program_selector #(.DIRECT_DROP_CYC(DCYC), .LOGIC1_DROP_CYC(LCYC)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .prog_count(prog_count),
        .app_name_in(app_name_in), .app_name_load(app_name_load),
        .sel_tested(sel_tested), .sel_test_pulse(sel_test_pulse),
        .mode_switch_a(mode_switch_a), .mode_switch_b(mode_switch_b),
        .forward_enable(forward_enable),
        .forward_simultaneous(forward_simultaneous),
        .filter_cycles(filter_cycles), .changeover_cycles(changeover_cycles),
        .direct_route_a(direct_route_a), .direct_route_b(direct_route_b),
        .logic1_route_a(logic1_route_a), .logic1_route_b(logic1_route_b),
        .sel_in(sel_in), .local_in(local_in), .bypass_active(bypass_active),
        .teach_active(teach_active), .delay_running(delay_running),
        .app_out_req(app_out_req), .app_out(app_out),
        .bypass_cancel(bypass_cancel), .active_prog(active_prog),
        .changing(changing), .app_restart(app_restart),
        .peer_data(peer_data), .peer_valid(peer_valid),
        .sel_invalid(sel_invalid), .app_name(app_name));

    psc_partner partner (
        .ref_clk(ref_clk), .pick(pick), .two_hot(two_hot),
        .bypass_on(bypass_on), .bypass_cancel(bypass_cancel),
        .peer_data(peer_data), .peer_valid(peer_valid), .sel_in(sel_in),
        .bypass_active(bypass_active), .peer_sel(peer_sel));

    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // The run is far shorter than this ceiling.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [175:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic select_prog(input logic [2:0] p);
        @(posedge ref_clk);
        pick <= p;
    endtask : select_prog

    // Waits for a changeover and counts low cycles of each output.
    task automatic wait_change();
        int n;
        n = 0;
        la = 0;
        lb = 0;
        rs = 0;
        while (changing !== 1'b1 && n < 300) begin
            idle(1);
            n++;
        end
        check("changing_start", changing, 1'b1);
        n = 0;
        while (changing === 1'b1 && n < 300) begin
            if (app_out[0] !== 1'b1) la++;
            if (app_out[1] !== 1'b1) lb++;
            idle(1);
            n++;
        end
        repeat (3) begin
            if (app_restart === 1'b1) rs = 1;
            idle(1);
        end
    endtask : wait_change

    initial begin
        idle(3);
        reset_n <= 1'b1;
        idle(3);
        check("active_prog", active_prog, 3'h0);
        check("changing", changing, 1'b0);
        @(posedge ref_clk);
        app_name_in <= {22{8'h41}};
        app_name_load <= 1'b1;
        @(posedge ref_clk);
        app_name_load <= 1'b0;
        idle(3);
        check("app_name", app_name, {22{8'h41}});
        // Operating-mode switching on A only, program switching on B.
        mode_switch_a <= 1'b1;
        select_prog(3'h1);
        wait_change();
        check("active_prog", active_prog, 3'h1);
        check("off_a", la >= 20, 1'b1);
        check("held_b", lb, 0);
        check("restart", rs, 1);
        check("peer_sel", peer_sel, 5'h02);
        check("app_out", app_out, 2'h3);
        // Program switching with direct and input-1 routes in program 2.
        mode_switch_a <= 1'b0;
        direct_route_a <= 5'h04;
        logic1_route_b <= 5'h04;
        select_prog(3'h2);
        wait_change();
        check("drop_a", la >= DCYC && la <= DCYC + 4, 1'b1);
        check("drop_b", lb >= LCYC && lb <= LCYC + 4, 1'b1);
        select_prog(3'h3);
        wait_change();
        check("no_drop", la + lb, 0);
        // A glitch shorter than the filter time is not accepted.
        select_prog(3'h4);
        idle(5);
        select_prog(3'h3);
        idle(60);
        check("filtered", active_prog, 3'h3);
        // Two closed contacts, then a contact beyond the configured count.
        @(posedge ref_clk);
        two_hot <= 1'b1;
        pick <= 3'h0;
        idle(40);
        check("two_hot", sel_invalid, 1'b1);
        check("kept", active_prog, 3'h3);
        @(posedge ref_clk);
        two_hot <= 1'b0;
        prog_count <= 3'h2;
        pick <= 3'h4;
        idle(40);
        check("beyond", sel_invalid, 1'b1);
        check("kept", active_prog, 3'h3);
        prog_count <= 3'h5;
        teach_active <= 1'b1;
        delay_running <= 1'b1;
        select_prog(3'h0);
        idle(60);
        check("teach_hold", active_prog, 3'h3);
        teach_active <= 1'b0;
        idle(30);
        check("delay_hold", active_prog, 3'h3);
        delay_running <= 1'b0;
        wait_change();
        check("active_prog", active_prog, 3'h0);
        check("peer_sel", peer_sel, 5'h01);
        // Bypass is cancelled before the new program is entered.
        bypass_on <= 1'b1;
        @(posedge ref_clk);
        bypass_on <= 1'b0;
        idle(2);
        check("bypass_on", bypass_active, 1'b1);
        select_prog(3'h1);
        wait_change();
        check("bypass_off", bypass_active, 1'b0);
        check("active_prog", active_prog, 3'h1);
        // A tested contact is ignored while its test pulse is high.
        sel_tested <= 1'b1;
        sel_test_pulse <= 5'h04;
        select_prog(3'h2);
        idle(40);
        check("masked", sel_invalid, 1'b1);
        check("masked_prog", active_prog, 3'h1);
        sel_test_pulse <= 5'h00;
        wait_change();
        check("tested", active_prog, 3'h2);
        forward_simultaneous <= 1'b0;
        local_in <= 5'h16;
        idle(4);
        check("peer_valid", peer_valid, 1'b1);
        check("peer_data", peer_data, 5'h16);
        finish_test();
    end
endmodule : psc_program_selector_tb_top
